// ==== dv/csp_checker.sv ====
`timescale 1ns/1ns
`include "csp_consts.svh"
module csp_checker (
    // system
    input wire logic CLK_SYS,
    input wire logic SRST,
    // instruction strobes
    input wire logic PEND_CFG_STB,
    input wire logic INIT_CFG_STB,
    // target pins
    input wire logic CONFIG_CLOCK_OUT,
    input wire logic [`CSP_DATA_W-1:0] CFG_DATA,
    input wire logic DONE_SENSE_INPUT,
    input wire logic TARGET_STATUS_LINE_I,
    input wire logic TARGET_STATUS_LINE_OE,
    input wire logic RECONFIG_REQUEST_OUT_OE,
    // status
    input wire logic FLASH_RELEASE,
    input wire logic CFG_BUSY,
    input wire logic CFG_OK,
    input wire logic CFG_ERROR
);
    logic pend_seen_reg;
    logic pend_seen_next;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // a pend instruction stays pending until an initiate strobe
    always_comb begin
        pend_seen_next = PEND_CFG_STB ? 1'b1 : (INIT_CFG_STB ? 1'b0 : pend_seen_reg);
    end
    always_ff @(posedge CLK_SYS) begin
        pend_seen_reg <= SRST ? 1'b0 : pend_seen_next;
    end
    // five samples so the level has surely crossed the input synchroniser
    sequence s_status_low;
        !TARGET_STATUS_LINE_I [*5];
    endsequence
    sequence s_status_high;
        TARGET_STATUS_LINE_I [*5];
    endsequence
    a_data_fall_only: assert property ($changed(CFG_DATA) |-> !CONFIG_CLOCK_OUT)
        else $error("data moved while the configuration clock was high");
    a_clock_in_busy: assert property ($rose(CONFIG_CLOCK_OUT) |-> CFG_BUSY)
        else $error("configuration clock pulsed outside a configuration");
    a_status_por_hold: assert property ($fell(SRST) |-> TARGET_STATUS_LINE_OE [*8])
        else $error("status line released too early after reset");
    a_status_once: assert property (!TARGET_STATUS_LINE_OE |=> !TARGET_STATUS_LINE_OE)
        else $error("status line driven again after release");
    a_low_stays_idle: assert property (s_status_low |-> !CFG_BUSY && !CONFIG_CLOCK_OUT)
        else $error("block proceeds while the status net is low");
    a_flash_low: assert property (s_status_low |-> FLASH_RELEASE)
        else $error("flash not released while status net low");
    a_flash_high: assert property (s_status_high |-> !FLASH_RELEASE)
        else $error("flash released while status net high");
    a_pend_assert: assert property (PEND_CFG_STB |=> RECONFIG_REQUEST_OUT_OE)
        else $error("pend strobe did not pull the request low");
    a_init_release: assert property (INIT_CFG_STB && !PEND_CFG_STB && pend_seen_reg |=> !RECONFIG_REQUEST_OUT_OE)
        else $error("initiate strobe did not release the request");
    a_init_pulse: assert property (INIT_CFG_STB && !pend_seen_reg |=> RECONFIG_REQUEST_OUT_OE [*8])
        else $error("initiate strobe gave no request pulse");
    a_ok_done: assert property ($rose(CFG_OK) |-> $past(DONE_SENSE_INPUT, 4) && !CFG_ERROR)
        else $error("success flagged without done");
    a_err_done: assert property ($rose(CFG_ERROR) |-> !$past(DONE_SENSE_INPUT, 4) && !CFG_OK)
        else $error("error flagged with done high");
endmodule

bind csp_top csp_checker u_csp_checker (.CLK_SYS(CLK_SYS), .SRST(SRST), .PEND_CFG_STB(PEND_CFG_STB),
    .INIT_CFG_STB(INIT_CFG_STB), .CONFIG_CLOCK_OUT(CONFIG_CLOCK_OUT), .CFG_DATA(CFG_DATA),
    .DONE_SENSE_INPUT(DONE_SENSE_INPUT), .TARGET_STATUS_LINE_I(TARGET_STATUS_LINE_I),
    .TARGET_STATUS_LINE_OE(TARGET_STATUS_LINE_OE), .RECONFIG_REQUEST_OUT_OE(RECONFIG_REQUEST_OUT_OE),
    .FLASH_RELEASE(FLASH_RELEASE), .CFG_BUSY(CFG_BUSY), .CFG_OK(CFG_OK), .CFG_ERROR(CFG_ERROR));

// ==== dv/csp_target_model.sv ====
`timescale 1ns/1ns
module csp_target_model (
    // pins from the configuration block
    input wire logic config_clock_out,
    input wire logic [7:0] cfg_data,
    input wire logic request_wire,
    // bench controls
    input wire logic hold_status,
    input wire logic fail,
    input wire logic [7:0] n_expect,
    // pins driven back
    output logic status_oe,
    output logic done_sense
);
    logic [7:0] got[$];
    initial done_sense = 1'b0;
    // request low resets the target, which drags status low; the bench may stretch power-on too
    assign status_oe = !request_wire || hold_status;
    always @(negedge request_wire) begin
        got = {};
        done_sense = 1'b0;
    end
    // a byte is latched on each rising clock edge until the image is complete; the extra
    // clocks that follow only finish start-up, and a failing image never signals done
    always @(posedge config_clock_out) begin
        if (request_wire && got.size() < n_expect) begin
            got.push_back(cfg_data);
            if (got.size() == n_expect && !fail) done_sense <= 1'b1;
        end
    end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, srst, in_last = 1'b0, in_valid = 1'b0, in_ready, por_long = 1'b0, clk_src_ext = 1'b0;
    logic pend_stb = 1'b0, init_stb = 1'b0, ext_clk = 1'b0, cclk, done_sense, stat_o, stat_oe, req_o, req_oe;
    logic flash_rel, busy, ok, err, p_oe, hold = 1'b1, fail = 1'b0;
    logic [7:0] in_data = 8'h00, cdata, n_exp = 8'h0c;
    logic [4:0] div_sel = 5'h01;
    logic [7:0] exp_q[$];
    logic [4:0] div_tab[4] = '{5'h01, 5'h11, 5'h10, 5'h12};
    int miscompares = 0, n_tests = 0, seed = 19601, k;
    time t0, dt;
    // the status net is wired-AND with a pull-up
    wire status_w = !(stat_oe || p_oe);
    wire req_w = !req_oe;
    always #2 clk = ~clk;
    // pin edges fall on odd times so they never race a system clock edge
    initial begin
        #1;
        forever #10 ext_clk = ~ext_clk;
    end
    csp_top #(.POR_SHORT_CYC(20), .POR_LONG_CYC(40), .OSC_HALF_CYC(2), .DONE_EXTRA_CLKS(2),
        .INIT_LOW_CYC(10)) u_csp_top (.CLK_SYS(clk), .SRST(srst), .IN_DATA(in_data),
        .IN_LAST(in_last), .IN_VALID(in_valid), .IN_READY(in_ready), .POR_LONG(por_long),
        .CLK_SRC_EXT(clk_src_ext), .DIV_SEL(div_sel), .PEND_CFG_STB(pend_stb), .INIT_CFG_STB(init_stb),
        .EXTERNAL_CLOCK_INPUT(ext_clk), .CONFIG_CLOCK_OUT(cclk), .CFG_DATA(cdata), .DONE_SENSE_INPUT(done_sense),
        .TARGET_STATUS_LINE_I(status_w), .TARGET_STATUS_LINE_O(stat_o), .TARGET_STATUS_LINE_OE(stat_oe),
        .RECONFIG_REQUEST_OUT_O(req_o), .RECONFIG_REQUEST_OUT_OE(req_oe), .FLASH_RELEASE(flash_rel),
        .CFG_BUSY(busy), .CFG_OK(ok), .CFG_ERROR(err));
    csp_target_model u_csp_target_model (.config_clock_out(cclk), .cfg_data(cdata), .request_wire(req_w),
        .hold_status(hold), .fail(fail), .n_expect(n_exp), .status_oe(p_oe), .done_sense(done_sense));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // valid is left high so back-to-back bytes never drop it within one step
    task push(input logic [7:0] d, input logic l);
        int w;
        in_data = d;
        in_last = l;
        in_valid = 1'b1;
        exp_q.push_back(d);
        w = 0;
        while (in_ready !== 1'b1 && w < 2000) begin
            tick(1);
            w++;
        end
        if (w == 2000) miscompares++;
        tick(1);
    endtask
    task por_check(input logic pl, input int lim);
        srst = 1'b1;
        por_long = pl;
        tick(5);
        srst = 1'b0;
        k = 0;
        while (stat_oe === 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        check("por_len", k >= lim && k <= lim + 3, 1);
    endtask
    // each image: hold the target back, fill the buffer, release, stream the rest, judge done
    task run_image(input int i);
        clk_src_ext = i[0];
        div_sel = div_tab[i];
        fail = (i == 3);
        exp_q = {};
        if (i > 0) begin
            pend_stb = 1'b1;
            tick(1);
            pend_stb = 1'b0;
        end
        for (int j = 0; j < 8; j++) push(8'($random(seed)), 1'b0);
        in_valid = 1'b0;
        tick(6);
        check("in_ready_full", in_ready, 0);
        check("busy_held", busy, 0);
        check("clk_static", cclk, 0);
        check("flash_rel", flash_rel, 1);
        check("stat_o", stat_o, 0);
        check("req_o", req_o, 0);
        check("req_oe_held", req_oe, i > 0);
        if (i == 0) hold = 1'b0;
        else begin
            init_stb = 1'b1;
            tick(1);
            init_stb = 1'b0;
            check("req_oe_free", req_oe, 0);
        end
        // one step per pin edge: 1.5 and 2.5 of a 20 ns pin clock, give or take the sync jitter
        @(posedge cclk);
        t0 = $time;
        @(posedge cclk);
        #1;
        dt = $time - t0 - 1;
        if (!i[0]) check("clk_period", dt / 4, 4 * div_tab[i]);
        else check("clk_period_ext", dt + 4 >= (i == 1 ? 30 : 50) && dt <= (i == 1 ? 34 : 54), 1);
        for (int j = 0; j < 4; j++) push(8'($random(seed)), j == 3);
        in_valid = 1'b0;
        k = 0;
        while (busy === 1'b1 && k < 5000) begin
            tick(1);
            k++;
        end
        if (k == 5000) miscompares++;
        check("cfg_ok", ok, !fail);
        check("cfg_error", err, fail);
        check("byte_count", u_csp_target_model.got.size(), 12);
        for (int j = 0; j < 12; j++) check("byte", u_csp_target_model.got[j], exp_q[j]);
    endtask
    initial begin
        por_check(1'b1, 40);
        por_check(1'b0, 20);
        for (int i = 0; i < 4; i++) run_image(i);
        // initiate without a pending pend gives a self-timed request pulse
        init_stb = 1'b1;
        tick(1);
        init_stb = 1'b0;
        k = 0;
        while (req_oe === 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        check("init_len", k, 10);
        tick(20);
        wrap_up;
    end
    // the whole run needs well under 10000 clocks
    initial begin
        #200000;
        miscompares++;
        wrap_up;
    end
endmodule

// ==== src/csp_consts.svh ====
// Function
// [R1] The 8-bit configuration data output changes only on a falling edge of the configuration clock.
// [R2] The target samples the configuration data byte on each rising edge of the configuration clock.
// [R3] This block generates the configuration clock and drives it out to the target.
// [R4] The done-sense input is the target's done flag and is checked for errors after the last byte is sent.
// [R5] While its configuration request is asserted, the target drives done-sense and the status line low.
// [R6] An open-drain output can pull the target's configuration request low to start a new configuration.
// [R7] The status line is held low while the power-on sequence is incomplete.
// [R8] At first power-up the status line is released after a selectable 2 ms or 100 ms hold.
// [R9] Anyone holding the status line low stretches the power-on period and the block does not proceed.
// [R10] After releasing its own drive, the block waits for the wired status line to read high before sending.
// [R11] The status line is a wired-AND net whose sensed level, not the own drive, steers the block.
// [R12] A pend instruction asserts the request output and holds it until the initiate instruction releases it.
// [R13] While the status line is low the controller stays in reset and releases its flash interface.
// [R14] The configuration clock comes from an internal oscillator or an external clock through a divider of 1..16, 1.5, 2.5.
// [R15] Before and after a configuration the clock and data outputs are held static.
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

`define CSP_CLK_MHZ 250
`define CSP_DATA_W 8
`define CSP_FIFO_DEPTH 8

// power-on hold times, in microseconds, and their cycle counts
`define CSP_POR_SHORT_US 2000
`define CSP_POR_LONG_US 100000
`define CSP_POR_SHORT_CYC (`CSP_POR_SHORT_US * `CSP_CLK_MHZ)
`define CSP_POR_LONG_CYC (`CSP_POR_LONG_US * `CSP_CLK_MHZ)

// internal oscillator, one tick per half period of its clock
`define CSP_OSC_MHZ 10
`define CSP_OSC_HALF_CYC (`CSP_CLK_MHZ / (2 * `CSP_OSC_MHZ))

// divider select codes beyond the plain integer range 1..16
`define CSP_DIV_CODE_1P5 5'h11
`define CSP_DIV_CODE_2P5 5'h12

// extra configuration clocks given to the target before done is checked
`define CSP_DONE_EXTRA_CLKS 16

// low time of a self-timed reconfiguration request, in ns
`define CSP_INIT_LOW_NS 1000
`define CSP_INIT_LOW_CYC ((`CSP_INIT_LOW_NS * `CSP_CLK_MHZ + 999) / 1000)

`endif

// ==== src/csp_fifo.sv ====
`timescale 1ns/1ns
module csp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // filling side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // draining side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic ready_reg, ready_next;
    logic push, pop;

    // ready is registered so the filling side sees a clean flop
    always_comb begin
        push = in_valid && ready_reg;
        pop = out_ready && (count_reg != '0);
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
        end
        count_next = count_reg + CW'(push) - CW'(pop);
        ready_next = (count_next < CW'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            ready_reg <= ready_next;
        end
    end

    // storage needs no reset; valid is guarded by the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    assign in_ready = ready_reg;
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
endmodule

// ==== src/csp_pkg.sv ====
package csp_pkg;
    typedef enum logic [2:0] {
        ST_POR,
        ST_WAIT_HIGH,
        ST_STREAM,
        ST_CHECK,
        ST_DONE,
        ST_ERROR
    } csp_state_e;
    typedef logic [5:0] csp_half_t;
endpackage

// ==== src/csp_top.sv ====
`timescale 1ns/1ns
`include "csp_consts.svh"
module csp_top import csp_pkg::*; #(
    parameter int POR_SHORT_CYC = `CSP_POR_SHORT_CYC,
    parameter int POR_LONG_CYC = `CSP_POR_LONG_CYC,
    parameter int OSC_HALF_CYC = `CSP_OSC_HALF_CYC,
    parameter int DONE_EXTRA_CLKS = `CSP_DONE_EXTRA_CLKS,
    parameter int INIT_LOW_CYC = `CSP_INIT_LOW_CYC,
    parameter int FIFO_DEPTH = `CSP_FIFO_DEPTH
) (
    // system
    input wire logic CLK_SYS,
    input wire logic SRST,
    // configuration byte stream from the flash side
    input wire logic [`CSP_DATA_W-1:0] IN_DATA,
    input wire logic IN_LAST,
    input wire logic IN_VALID,
    output logic IN_READY,
    // settings
    input wire logic POR_LONG,
    input wire logic CLK_SRC_EXT,
    input wire logic [4:0] DIV_SEL,
    // instruction strobes from the test port
    input wire logic PEND_CFG_STB,
    input wire logic INIT_CFG_STB,
    // external clock pin
    input wire logic EXTERNAL_CLOCK_INPUT,
    // target pins
    output logic CONFIG_CLOCK_OUT,
    output logic [`CSP_DATA_W-1:0] CFG_DATA,
    input wire logic DONE_SENSE_INPUT,
    input wire logic TARGET_STATUS_LINE_I,
    output logic TARGET_STATUS_LINE_O,
    output logic TARGET_STATUS_LINE_OE,
    output logic RECONFIG_REQUEST_OUT_O,
    output logic RECONFIG_REQUEST_OUT_OE,
    // status
    output logic FLASH_RELEASE,
    output logic CFG_BUSY,
    output logic CFG_OK,
    output logic CFG_ERROR
);
    // half periods of the source clock per configuration clock period
    function automatic csp_half_t half_edges(input logic [4:0] sel);
        csp_half_t r;
        r = 6'h02;
        if (sel == `CSP_DIV_CODE_1P5) begin
            r = 6'h03;
        end else if (sel == `CSP_DIV_CODE_2P5) begin
            r = 6'h05;
        end else if (sel >= 5'h01 && sel <= 5'h10) begin
            r = {sel, 1'b0};
        end
        return r;
    endfunction

    logic [2:0] sync1_reg, sync2_reg;
    logic status_hi, done_hi, ext_lvl;
    logic ext_prev_reg, ext_prev_next;
    logic [15:0] osc_cnt_reg, osc_cnt_next;
    logic src_tick;
    csp_half_t p2, lo_len, nxt_cnt;
    csp_state_e state_reg, state_next;
    logic [31:0] por_cnt_reg, por_cnt_next, por_last;
    csp_half_t half_cnt_reg, half_cnt_next;
    logic config_clock_out_reg, config_clock_out_next;
    logic [`CSP_DATA_W-1:0] data_reg, data_next;
    logic last_reg, last_next;
    logic [15:0] extra_cnt_reg, extra_cnt_next;
    logic status_oe_reg, status_oe_next;
    logic flash_rel_reg, flash_rel_next;
    logic busy_reg, busy_next, ok_reg, ok_next, err_reg, err_next;
    logic wrap, adv, pop;
    logic pend_reg, pend_next, req_oe_reg, req_oe_next;
    logic [15:0] init_cnt_reg, init_cnt_next;
    logic low_reg;
    logic [`CSP_DATA_W:0] fifo_data;
    logic fifo_valid;

    // pins from outside pass two flops; first stage feeds only the second
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sync1_reg <= 3'h1;
            sync2_reg <= 3'h1;
        end else begin
            sync1_reg <= {EXTERNAL_CLOCK_INPUT, DONE_SENSE_INPUT, TARGET_STATUS_LINE_I};
            sync2_reg <= sync1_reg;
        end
    end
    assign status_hi = sync2_reg[0]; // R11
    assign done_hi = sync2_reg[1];
    assign ext_lvl = sync2_reg[2];

    // clock source: every edge of the external pin or each oscillator half period
    // is one step; the sync costs two cycles, so the pin must be slower than CLK_SYS/4
    always_comb begin
        ext_prev_next = ext_lvl;
        osc_cnt_next = (osc_cnt_reg == 16'(OSC_HALF_CYC - 1)) ? 16'h0000 : osc_cnt_reg + 16'h0001;
        src_tick = CLK_SRC_EXT ? (ext_lvl ^ ext_prev_reg) : (osc_cnt_reg == 16'(OSC_HALF_CYC - 1)); // R14
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ext_prev_reg <= 1'b0;
            osc_cnt_reg <= 16'h0000;
        end else begin
            ext_prev_reg <= ext_prev_next;
            osc_cnt_reg <= osc_cnt_next;
        end
    end

    // divider: low for the first lo_len steps, high for the rest, so odd
    // step counts give the 1.5 and 2.5 ratios at uneven duty
    assign p2 = half_edges(DIV_SEL); // R14
    assign lo_len = p2 - (p2 >> 1);

    // main sequencer
    always_comb begin
        state_next = state_reg;
        por_cnt_next = por_cnt_reg;
        half_cnt_next = half_cnt_reg;
        config_clock_out_next = config_clock_out_reg;
        data_next = data_reg;
        last_next = last_reg;
        extra_cnt_next = extra_cnt_reg;
        status_oe_next = status_oe_reg;
        busy_next = busy_reg;
        ok_next = ok_reg;
        err_next = err_reg;
        flash_rel_next = !status_hi; // R13
        pop = 1'b0;
        adv = 1'b0;
        wrap = (half_cnt_reg == p2 - 6'h01);
        nxt_cnt = wrap ? 6'h00 : half_cnt_reg + 6'h01;
        por_last = POR_LONG ? 32'(POR_LONG_CYC - 1) : 32'(POR_SHORT_CYC - 1);
        case (state_reg)
            ST_POR: begin
                status_oe_next = 1'b1; // R7
                por_cnt_next = por_cnt_reg + 32'h00000001;
                if (por_cnt_reg >= por_last) begin // R8
                    status_oe_next = 1'b0;
                    state_next = ST_WAIT_HIGH;
                end
            end
            ST_WAIT_HIGH: begin
                config_clock_out_next = 1'b0; // R15
                half_cnt_next = 6'h00;
                if (status_hi && fifo_valid) begin // R9 R10
                    pop = 1'b1;
                    data_next = fifo_data[`CSP_DATA_W-1:0];
                    last_next = fifo_data[`CSP_DATA_W];
                    busy_next = 1'b1;
                    ok_next = 1'b0;
                    err_next = 1'b0;
                    state_next = ST_STREAM;
                end
            end
            ST_STREAM, ST_CHECK: begin
                if (!status_hi) begin // R9 R13
                    config_clock_out_next = 1'b0;
                    busy_next = 1'b0;
                    state_next = ST_WAIT_HIGH;
                end else if (src_tick) begin
                    if (!wrap) begin
                        adv = 1'b1; // R3
                    end else if (state_reg == ST_CHECK) begin
                        extra_cnt_next = extra_cnt_reg + 16'h0001;
                        if (extra_cnt_reg == 16'(DONE_EXTRA_CLKS - 1)) begin
                            busy_next = 1'b0;
                            ok_next = done_hi; // R4
                            err_next = !done_hi; // R4
                            state_next = done_hi ? ST_DONE : ST_ERROR;
                        end else begin
                            adv = 1'b1;
                        end
                    end else if (last_reg) begin
                        adv = 1'b1;
                        extra_cnt_next = 16'h0000;
                        state_next = ST_CHECK;
                    end else if (fifo_valid) begin
                        // next byte rides the falling edge; the target takes it on the rise
                        adv = 1'b1;
                        pop = 1'b1;
                        data_next = fifo_data[`CSP_DATA_W-1:0]; // R1 R2
                        last_next = fifo_data[`CSP_DATA_W];
                    end
                    // an empty buffer stretches the high phase rather than send junk
                end
            end
            ST_DONE, ST_ERROR: begin
                config_clock_out_next = 1'b0; // R15
                if (!status_hi) begin // R5
                    state_next = ST_WAIT_HIGH;
                end
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
        if (adv) begin
            half_cnt_next = nxt_cnt;
            config_clock_out_next = (nxt_cnt >= lo_len); // R3
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_reg <= ST_POR;
            por_cnt_reg <= 32'h00000000;
            half_cnt_reg <= 6'h00;
            config_clock_out_reg <= 1'b0;
            data_reg <= 8'h00;
            last_reg <= 1'b0;
            extra_cnt_reg <= 16'h0000;
            status_oe_reg <= 1'b1;
            flash_rel_reg <= 1'b0;
            busy_reg <= 1'b0;
            ok_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            por_cnt_reg <= por_cnt_next;
            half_cnt_reg <= half_cnt_next;
            config_clock_out_reg <= config_clock_out_next;
            data_reg <= data_next;
            last_reg <= last_next;
            extra_cnt_reg <= extra_cnt_next;
            status_oe_reg <= status_oe_next;
            flash_rel_reg <= flash_rel_next;
            busy_reg <= busy_next;
            ok_reg <= ok_next;
            err_reg <= err_next;
        end
    end

    // reconfiguration request: pend holds it, initiate releases it or,
    // with nothing pending, gives a self-timed low pulse
    always_comb begin
        pend_next = pend_reg;
        req_oe_next = req_oe_reg;
        init_cnt_next = init_cnt_reg;
        if (PEND_CFG_STB) begin
            pend_next = 1'b1; // R12
            req_oe_next = 1'b1;
        end else if (INIT_CFG_STB) begin
            if (pend_reg) begin
                pend_next = 1'b0; // R12
                req_oe_next = 1'b0;
            end else begin
                req_oe_next = 1'b1; // R6
                init_cnt_next = 16'(INIT_LOW_CYC - 1);
            end
        end else if (req_oe_reg && !pend_reg) begin
            if (init_cnt_reg == 16'h0000) begin
                req_oe_next = 1'b0; // R6
            end else begin
                init_cnt_next = init_cnt_reg - 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pend_reg <= 1'b0;
            req_oe_reg <= 1'b0;
            init_cnt_reg <= 16'h0000;
            low_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            req_oe_reg <= req_oe_next;
            init_cnt_reg <= init_cnt_next;
            low_reg <= 1'b0;
        end
    end

    // byte buffer between the flash side and the target link
    csp_fifo #(
        .WIDTH(`CSP_DATA_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .srst(SRST),
        .in_data({IN_LAST, IN_DATA}),
        .in_valid(IN_VALID),
        .in_ready(IN_READY),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    // outputs straight from flops; open-drain pins only ever drive low
    assign CONFIG_CLOCK_OUT = config_clock_out_reg;
    assign CFG_DATA = data_reg;
    assign TARGET_STATUS_LINE_O = low_reg;
    assign TARGET_STATUS_LINE_OE = status_oe_reg;
    assign RECONFIG_REQUEST_OUT_O = low_reg;
    assign RECONFIG_REQUEST_OUT_OE = req_oe_reg;
    assign FLASH_RELEASE = flash_rel_reg;
    assign CFG_BUSY = busy_reg;
    assign CFG_OK = ok_reg;
    assign CFG_ERROR = err_reg;
endmodule
